// ==== rtl/cmb_mailbox.sv ====
// Thirty-two slot CAN mailbox request and completion control.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "cmb_defines.svh"
module cmb_mailbox
  import cmb_pkg::*;
#(
  parameter int NSLOT = 32
)(
  input  wire logic        CLK,        // 25 MHz clock
  input  wire logic        RESET,      // Synchronous reset, high
  input  wire logic [7:0]  ADDR,       // Register byte address
  input  wire logic [31:0] WDATA,      // Write data
  input  wire logic        WR,         // Write strobe
  input  wire logic        RD,         // Read strobe
  output logic      [31:0] RDATA,      // Read data, cycle after RD
  input  wire logic        TX_DONE,    // Engine: frame sent pulse
  input  wire logic        TX_ABT_OK,  // Engine: cancel took effect
  input  wire logic        RX_DONE,    // Engine: frame stored pulse
  input  wire logic [4:0]  ENG_SLOT,   // Engine: slot of event
  output logic [31:0]      TX_PEND,    // Slots queued to send
  output logic [31:0]      RX_EN,      // Slots accepting frames
  output logic [31:0]      ABT_REQ,    // Slots asking to cancel
  output logic             IRQ         // Level interrupt
);
  logic [7:0]               ctl   [NSLOT];
  logic [NSLOT-1:0]         pend_w, abt_w, rxen_w;
  logic [2:0]               evt   [NSLOT];
  logic [`CMB_EVT_WIDTH-1:0] evs_q, evs_d, msk_q, msk_d, evt_or;
  logic [31:0]              rdata_q, rdata_d;
  logic [31:0]              pend_q, abt_q, rxen_q;
  logic                     irq_q, irq_d;
  logic                     slot_hit;
  logic [4:0]               slot_ix;

  assign slot_hit = (ADDR[7] == 1'b0) && (ADDR[1:0] == 2'b00);
  assign slot_ix  = ADDR[6:2];

  // =====================================================================
  // Slots
  for (genvar i = 0; i < NSLOT; i++) begin : g_slot              // RULE1
    cmb_slot u_slot (
      .clk      (CLK),
      .reset    (RESET),
      .wr       (WR && slot_hit && (slot_ix == 5'(i))),
      .wdata    (WDATA[7:0]),
      .tx_done  (TX_DONE && (ENG_SLOT == 5'(i))),
      .tx_abtok (TX_ABT_OK && (ENG_SLOT == 5'(i))),
      .rx_done  (RX_DONE && (ENG_SLOT == 5'(i))),
      .ctl      (ctl[i]),
      .tx_pend  (pend_w[i]),
      .abt_req  (abt_w[i]),
      .evt      (evt[i])
    );
    assign rxen_w[i] = ctl[i][`CMB_BIT_RXREQ];
  end

  // =====================================================================
  // Events, mask and read mux
  always_comb begin
    evt_or = `CMB_EVT_RESET;
    for (int k = 0; k < NSLOT; k++) begin
      evt_or = evt_or | evt[k];
    end
    evs_d = evs_q;
    msk_d = msk_q;
    if (WR && ADDR == `CMB_STAT_OFFS) begin
      evs_d = evs_q & ~WDATA[`CMB_EVT_WIDTH-1:0];
    end
    if (WR && ADDR == `CMB_MASK_OFFS) begin
      msk_d = WDATA[`CMB_EVT_WIDTH-1:0];
    end
    evs_d   = evs_d | evt_or;
    irq_d   = |(evs_d & msk_d);
    rdata_d = 32'h0000_0000;
    if (RD) begin
      if (slot_hit) begin
        rdata_d = {24'h00_0000, ctl[slot_ix]};
      end else if (ADDR == `CMB_STAT_OFFS) begin
        rdata_d = {29'h0000_0000, evs_q};
      end else if (ADDR == `CMB_MASK_OFFS) begin
        rdata_d = {29'h0000_0000, msk_q};
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      evs_q   <= `CMB_EVT_RESET;
      msk_q   <= `CMB_EVT_RESET;
      rdata_q <= 32'h0000_0000;
      irq_q   <= 1'b0;
      pend_q  <= 32'h0000_0000;
      abt_q   <= 32'h0000_0000;
      rxen_q  <= 32'h0000_0000;
    end else begin
      evs_q   <= evs_d;
      msk_q   <= msk_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
      pend_q  <= 32'(pend_w);
      abt_q   <= 32'(abt_w);
      rxen_q  <= 32'(rxen_w);
    end
  end

  assign RDATA   = rdata_q;
  assign IRQ     = irq_q;
  assign TX_PEND = pend_q;
  assign ABT_REQ = abt_q;
  assign RX_EN   = rxen_q;

  // =====================================================================
  // Checks
  irq_level_a: assert property (@(posedge CLK) disable iff (RESET)
    IRQ == |($past(evs_d) & $past(msk_d)))
    else $error("interrupt level mismatch");
  rx_flag_set_a: assert property (@(posedge CLK) disable iff (RESET) // RULE8
    (RX_DONE && rxen_w[ENG_SLOT]) |=> evs_q[`CMB_EVT_RX])
    else $error("receive event not recorded");
  tx_flag_set_a: assert property (@(posedge CLK) disable iff (RESET) // RULE6
    (TX_DONE && TX_PEND[ENG_SLOT] && pend_w[ENG_SLOT])
      |=> ctl[$past(ENG_SLOT)][`CMB_BIT_TXDONE])
    else $error("transmit done flag not set");
  indep_cfg_a: assert property (@(posedge CLK) disable iff (RESET) // RULE3
    (WR && slot_hit) |=> ctl[$past(slot_ix)][`CMB_BIT_RXREQ]
      == $past(WDATA[`CMB_BIT_RXREQ]))
    else $error("receive config not taken independently");
  rxreq_reset_a: assert property (@(posedge CLK) // RULE2
    RESET |=> RX_EN == 32'h0000_0000 && TX_PEND == 32'h0000_0000
      && ABT_REQ == 32'h0000_0000 && !IRQ)
    else $error("outputs not cleared by reset");
  rdata_idle_a: assert property (@(posedge CLK) disable iff (RESET)
    !RD |=> RDATA == 32'h0000_0000)
    else $error("read data not zero outside a read");
  abort_pend_a: assert property (@(posedge CLK) disable iff (RESET) // RULE5
    (ABT_REQ & ~TX_PEND) == 32'h0000_0000)
    else $error("cancel request on an idle slot");
  status_sticky_a: assert property (@(posedge CLK) disable iff (RESET)
    (|($past(evs_q) & ~evs_q)) |-> $past(WR && ADDR == `CMB_STAT_OFFS))
    else $error("status bit cleared without write");
  mask_take_a: assert property (@(posedge CLK) disable iff (RESET)
    (WR && ADDR == `CMB_MASK_OFFS)
      |=> msk_q == $past(WDATA[`CMB_EVT_WIDTH-1:0]))
    else $error("mask write not taken");
  tx_start_a: assert property (@(posedge CLK) disable iff (RESET) // RULE4
    (WR && slot_hit && WDATA[`CMB_BIT_TXREQ]
      && !ctl[slot_ix][`CMB_BIT_TXREQ])
      |=> pend_w[$past(slot_ix)])
    else $error("transmit not started on request rise");
endmodule : cmb_mailbox

// ==== rtl/cmb_defines.svh ====
// Register map, field positions, reset values and other constants.
// Notes on behaviour
// [RULE1] Thirty-two slots, each with control register
// [RULE2] Receive request bit enables reception, resets zero
// [RULE3] Transmit and receive configuration bits independent
// [RULE4] Transmit request starts sending, never self-cleared
// [RULE5] Request falling one to zero aborts message
// [RULE6] Transmit done set on completion, cleared writing zero
// [RULE7] Abort done set only on successful cancel
// [RULE8] Receive done set when frame fully received
// [RULE9] Receive done cleared only by writing zero
// [RULE10] Writing one never sets completion flags
`ifndef CMB_DEFINES_SVH
`define CMB_DEFINES_SVH

// =====================================================================
// Register map
`define CMB_SLOT_BASE    8'h00
`define CMB_STAT_OFFS    8'h80
`define CMB_MASK_OFFS    8'h84
`define CMB_EVT_OFFS     8'h88

// =====================================================================
// Slot control fields
`define CMB_BIT_TXDONE   0
`define CMB_BIT_RXDONE   1
`define CMB_BIT_ABTDONE  2
`define CMB_BIT_RXREQ    6
`define CMB_BIT_TXREQ    7
`define CMB_CTL_RESET    8'h00

// =====================================================================
// Event status bits
`define CMB_EVT_TX       0
`define CMB_EVT_ABT      1
`define CMB_EVT_RX       2
`define CMB_EVT_WIDTH    3
`define CMB_EVT_RESET    3'h0

`endif

// ==== rtl/cmb_pkg.sv ====
// Types shared by the mailbox control block.
package cmb_pkg;
  typedef enum logic [2:0] {
    CMB_IDLE = 3'b001,
    CMB_BUSY = 3'b010,
    CMB_ABRT = 3'b100
  } cmb_txst_t;
endpackage : cmb_pkg

// ==== rtl/cmb_slot.sv ====
// One message slot: control bits, transmit state and completion flags.
`timescale 1ns/1ps
`include "cmb_defines.svh"
module cmb_slot
  import cmb_pkg::*;
(
  input  wire logic       clk,      // Clock
  input  wire logic       reset,    // Synchronous reset
  input  wire logic       wr,       // Write to this slot
  input  wire logic [7:0] wdata,    // Write data
  input  wire logic       tx_done,  // Engine finished this slot's frame
  input  wire logic       tx_abtok, // Engine dropped this slot's frame
  input  wire logic       rx_done,  // Engine stored a frame here
  output logic      [7:0] ctl,      // Control register value
  output logic            tx_pend,  // Transmit queued or running
  output logic            abt_req,  // Cancel request to engine
  output logic      [2:0] evt       // Pulses: tx done, abort, rx done
);
  logic        txreq_q, txreq_d, rxreq_q, rxreq_d;
  logic        txf_q, txf_d, abf_q, abf_d, rxf_q, rxf_d;
  cmb_txst_t   st_q, st_d;
  logic        req_rise, req_fall;

  // =====================================================================
  // Next state
  always_comb begin
    txreq_d  = txreq_q;
    rxreq_d  = rxreq_q;
    txf_d    = txf_q;
    abf_d    = abf_q;
    rxf_d    = rxf_q;
    st_d     = st_q;
    evt      = 3'h0;
    req_rise = wr && wdata[`CMB_BIT_TXREQ] && !txreq_q;
    req_fall = wr && !wdata[`CMB_BIT_TXREQ] && txreq_q;
    if (wr) begin
      txreq_d = wdata[`CMB_BIT_TXREQ];                        // RULE3
      rxreq_d = wdata[`CMB_BIT_RXREQ];                        // RULE2
      // Zero clears a flag, one leaves it alone
      if (!wdata[`CMB_BIT_TXDONE])  txf_d = 1'b0;             // RULE10
      if (!wdata[`CMB_BIT_ABTDONE]) abf_d = 1'b0;             // RULE10
      if (!wdata[`CMB_BIT_RXDONE])  rxf_d = 1'b0;             // RULE9
    end
    case (st_q)
      CMB_IDLE: begin
        if (req_rise) begin
          st_d = CMB_BUSY;                                    // RULE4
        end
      end
      CMB_BUSY: begin
        if (tx_done) begin
          st_d                 = CMB_IDLE;
          txf_d                = 1'b1;                        // RULE6
          evt[`CMB_EVT_TX]     = 1'b1;
        end else if (req_fall) begin
          st_d = CMB_ABRT;                                    // RULE5
        end
      end
      CMB_ABRT: begin
        if (tx_done) begin
          // Frame won the race: no abort flag
          st_d             = CMB_IDLE;
          txf_d            = 1'b1;                            // RULE7
          evt[`CMB_EVT_TX] = 1'b1;
        end else if (tx_abtok) begin
          st_d              = CMB_IDLE;
          abf_d             = 1'b1;                           // RULE7
          evt[`CMB_EVT_ABT] = 1'b1;
        end
      end
      default: st_d = CMB_IDLE;
    endcase
    if (rx_done && rxreq_q) begin
      rxf_d            = 1'b1;                                // RULE8
      evt[`CMB_EVT_RX] = 1'b1;
    end
  end

  // =====================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (reset) begin
      txreq_q <= 1'b0;
      rxreq_q <= 1'b0;
      txf_q   <= 1'b0;
      abf_q   <= 1'b0;
      rxf_q   <= 1'b0;
      st_q    <= CMB_IDLE;
    end else begin
      txreq_q <= txreq_d;
      rxreq_q <= rxreq_d;
      txf_q   <= txf_d;
      abf_q   <= abf_d;
      rxf_q   <= rxf_d;
      st_q    <= st_d;
    end
  end

  always_comb begin
    ctl                   = `CMB_CTL_RESET;
    ctl[`CMB_BIT_TXREQ]   = txreq_q;
    ctl[`CMB_BIT_RXREQ]   = rxreq_q;
    ctl[`CMB_BIT_TXDONE]  = txf_q;
    ctl[`CMB_BIT_ABTDONE] = abf_q;
    ctl[`CMB_BIT_RXDONE]  = rxf_q;
    tx_pend               = (st_q != CMB_IDLE);
    abt_req               = (st_q == CMB_ABRT);
  end

  // =====================================================================
  // Checks
  txreq_kept_a: assert property (@(posedge clk) disable iff (reset) // RULE4
    $fell(txreq_q) |-> $past(wr) && !$past(wdata[`CMB_BIT_TXREQ]))
    else $error("transmit request dropped without write");
  done_noset_a: assert property (@(posedge clk) disable iff (reset) // RULE10
    $rose(txf_q) |-> $past(tx_done))
    else $error("done flag set without completion");
  abort_cause_a: assert property (@(posedge clk) disable iff (reset) // RULE7
    $rose(abf_q) |-> $past(st_q == CMB_ABRT && tx_abtok && !tx_done))
    else $error("abort flag without successful cancel");
  rx_hold_a: assert property (@(posedge clk) disable iff (reset) // RULE9
    $fell(rxf_q) |-> $past(wr && !wdata[`CMB_BIT_RXDONE]))
    else $error("receive flag cleared without write");
  cancel_go_a: assert property (@(posedge clk) disable iff (reset) // RULE5
    (st_q == CMB_BUSY && req_fall && !tx_done) |=> abt_req)
    else $error("cancel not raised after request fall");
  rx_cause_a: assert property (@(posedge clk) disable iff (reset) // RULE10
    $rose(rxf_q) |-> $past(rx_done && rxreq_q))
    else $error("receive flag set without stored frame");
endmodule : cmb_slot

// ==== dv/cmb_engine.sv ====
// Behavioural CAN protocol engine facing the slot control block.
`timescale 1ns/1ps
module cmb_engine (
  input  wire logic       clk,      // Clock
  input  wire logic       go,       // Command strobe from the bench
  input  wire logic [1:0] kind,     // 1 sent, 2 cancelled, 3 received
  input  wire logic [4:0] slot,     // Slot of the command, held by bench
  input  wire logic [3:0] dly,      // Cycles before the answer
  output logic            tx_done,  // Frame sent pulse
  output logic            abt_ok,   // Cancel done pulse
  output logic            rx_done,  // Frame stored pulse
  output logic      [4:0] eng_slot  // Slot of the pulse
);
  logic [3:0] cnt;
  logic       busy;
  initial begin
    {tx_done, abt_ok, rx_done, busy, cnt} = '0;
    eng_slot = 5'h1F;
  end
  always @(posedge clk) begin
    {tx_done, abt_ok, rx_done} <= 3'b000;
    // Slot lines carry no meaning outside a pulse
    eng_slot <= ~eng_slot;
    if (go) begin
      busy <= 1'b1;
      cnt  <= dly;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy     <= 1'b0;
      eng_slot <= slot;
      tx_done  <= (kind == 2'd1);
      abt_ok   <= (kind == 2'd2);
      rx_done  <= (kind == 2'd3);
    end
  end
endmodule : cmb_engine

// ==== dv/cmb_mailbox_bench.sv ====
// Self-checking bench for the mailbox request and completion block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("unexpected %s exp %h got %h", nm, e, g); \
  end \
end
module cmb_mailbox_bench;
  logic        clk, reset, wr_s, rd_s, irq, tx_d, abt, rx_d, go;
  logic [7:0]  addr, a;
  logic [31:0] wdata, rdata, tx_pend, rx_en, abt_req;
  logic [4:0]  eng_slot, slot, s;
  logic [1:0]  kind;
  logic [3:0]  dly;
  int          n_mismatch, comparisons;

  cmb_mailbox #(.NSLOT(32)) u_dut (.CLK(clk), .RESET(reset), .ADDR(addr),
    .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .TX_DONE(tx_d),
    .TX_ABT_OK(abt), .RX_DONE(rx_d), .ENG_SLOT(eng_slot),
    .TX_PEND(tx_pend), .RX_EN(rx_en), .ABT_REQ(abt_req), .IRQ(irq));
  cmb_engine u_eng (.clk(clk), .go(go), .kind(kind), .slot(slot),
    .dly(dly), .tx_done(tx_d), .abt_ok(abt), .rx_done(rx_d),
    .eng_slot(eng_slot));

  always #20 clk = ~clk;

  // Expected slot control word
  function automatic logic [31:0] ctl(logic t, r, ab, n, sd);
    return {24'h00_0000, t, r, 3'b000, ab, n, sd};
  endfunction : ctl

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr  <= ad;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 `CHK("read data", e, rdata)
  endtask : rd

  // Engine answers after a random delay, prompt or slow
  task automatic eng(input logic [1:0] k, input logic [4:0] sl);
    @(posedge clk);
    kind <= k;
    slot <= sl;
    dly  <= 4'($urandom_range(0, 9));
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : eng

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  initial begin
    {clk, wr_s, rd_s, go, kind, slot, dly, addr, wdata} = '0;
    reset       = 1'b1;
    n_mismatch  = 0;
    comparisons = 0;
    void'($urandom(37827));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int j = 0; j < 32; j++) rd(8'(4 * j), 32'h0000_0000);
    rd(8'h90, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      s = (i == 0) ? 5'd0 : (i == 1) ? 5'd31 : 5'($urandom_range(0, 31));
      a = 8'(4 * s);
      eng(2'd3, s);
      rd(a, 32'h0000_0000);
      wr(a, 32'hFFFF_FF40);
      rd(a, ctl(0, 1, 0, 0, 0));
      `CHK("rx enable", 1'b1, rx_en[s])
      eng(2'd3, s);
      rd(a, ctl(0, 1, 0, 1, 0));
      wr(a, 32'h0000_00C7);
      rd(a, ctl(1, 1, 0, 1, 0));
      `CHK("tx pending", 1'b1, tx_pend[s])
      eng(2'd1, s);
      rd(a, ctl(1, 1, 0, 1, 1));
      wr(a, 32'h0000_00C2);
      rd(a, ctl(1, 1, 0, 1, 0));
      wr(a, 32'h0000_0040);
      rd(a, ctl(0, 1, 0, 0, 0));
      wr(a, 32'h0000_00C0);
      wr(a, 32'h0000_0040);
      rd(a, ctl(0, 1, 0, 0, 0));
      `CHK("cancel request", 1'b1, abt_req[s])
      eng(2'd2, s);
      rd(a, ctl(0, 1, 1, 0, 0));
      `CHK("cancel request", 1'b0, abt_req[s])
      wr(a, 32'h0000_0044);
      rd(a, ctl(0, 1, 1, 0, 0));
      wr(a, 32'h0000_0080);
      wr(a, 32'h0000_0000);
      eng(2'd1, s);
      rd(a, ctl(0, 0, 0, 0, 1));
      wr(a, 32'h0000_0000);
      rd(a, 32'h0000_0000);
      $display("test slot %0d done", s);
    end
    // A completion for an idle slot must be ignored
    eng(2'd1, s);
    rd(a, 32'h0000_0000);
    rd(8'h80, 32'h0000_0007);
    `CHK("irq masked", 1'b0, irq)
    wr(8'h84, 32'h0000_0004);
    rd(8'h84, 32'h0000_0004);
    `CHK("irq raised", 1'b1, irq)
    wr(8'h80, 32'h0000_0007);
    rd(8'h80, 32'h0000_0000);
    `CHK("irq cleared", 1'b0, irq)
    $display("test interrupt done");
    // Reset in mid-run with a slot queued and receiving
    wr(8'h00, 32'h0000_00C0);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 `CHK("rx enable", 32'h0000_0000, rx_en)
    `CHK("tx pending", 32'h0000_0000, tx_pend)
    rd(8'h00, 32'h0000_0000);
    $display("test reset in run done");
    test_done();
  end

  initial begin
    #(40 * 20000);
    n_mismatch++;
    test_done();
  end
endmodule : cmb_mailbox_bench
